// [owsl_pkg.sv]
`default_nettype none
package owsl_pkg;
	localparam int unsigned CLK_MHZ          = 100;
	localparam int unsigned TMR_W            = 20;
	localparam int unsigned ROM_BITS         = 64;
	// times in microseconds, picked inside the allowed windows
	localparam int unsigned SLOT_SAMPLE_US   = 30;
	localparam int unsigned PRESENCE_WAIT_US = 30;
	localparam int unsigned PRESENCE_LOW_US  = 120;
	localparam int unsigned RESET_DETECT_US  = 240;
	localparam int unsigned IRQ_PULSE_US     = 1920;
	localparam int unsigned SLOT_SAMPLE_CYC  = SLOT_SAMPLE_US * CLK_MHZ;
	localparam int unsigned PRESENCE_WAIT_CYC = PRESENCE_WAIT_US * CLK_MHZ;
	localparam int unsigned PRESENCE_LOW_CYC = PRESENCE_LOW_US * CLK_MHZ;
	localparam int unsigned RESET_DETECT_CYC = RESET_DETECT_US * CLK_MHZ;
	localparam int unsigned IRQ_PULSE_CYC    = IRQ_PULSE_US * CLK_MHZ;
	// rom function commands
	localparam logic [7:0] CMD_READ_ROM      = 8'h33;
	localparam logic [7:0] CMD_MATCH_ROM     = 8'h55;
	localparam logic [7:0] CMD_SKIP_ROM      = 8'hCC;
	localparam logic [7:0] CMD_SEARCH_ROM    = 8'hF0;
	localparam logic [7:0] CMD_SEARCH_IRQ    = 8'hEC;
	// alarm_status register and its field positions
	localparam logic [15:0] ALARM_STATUS_ADDR = 16'h0200;
	localparam int unsigned CYCLE_FLAG_POS    = 0;
	localparam int unsigned INTERVAL_FLAG_POS = 1;
	localparam int unsigned CLOCK_FLAG_POS    = 2;
	localparam logic [7:0] ALARM_STATUS_RESET = 8'h00;

	typedef struct packed {
		logic clock;
		logic interval;
		logic cycle;
	} owsl_alarm_s;

	typedef enum logic [3:0] {
		S_PRES_WAIT = 4'h0,
		S_PRES_LOW  = 4'h1,
		S_ROM_CMD   = 4'h2,
		S_READ_ROM  = 4'h3,
		S_MATCH     = 4'h4,
		S_SEARCH    = 4'h5,
		S_MEM       = 4'h6,
		S_SILENT    = 4'h7,
		S_IRQ_PULSE = 4'h8
	} owsl_state_e;
endpackage
`default_nettype wire

// [owsl_line_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module owsl_line_sync (
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic line_i,
	output logic      level_o,
	output logic      fall_o,
	output logic      rise_o
);
	logic meta;
	logic stable;
	logic prev;
	logic next_meta;
	logic next_stable;
	logic next_prev;

	// the idle bus is high, so every stage resets high
	always_comb begin
		next_meta   = line_i;
		next_stable = meta;
		next_prev   = stable;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta   <= 1'b1;
			stable <= 1'b1;
			prev   <= 1'b1;
		end else begin
			meta   <= next_meta;
			stable <= next_stable;
			prev   <= next_prev;
		end
	end

	assign level_o = stable;
	assign fall_o  = prev & ~stable;
	assign rise_o  = ~prev & stable;
endmodule // owsl_line_sync
`default_nettype wire

// [owsl_slave.sv]
`timescale 1ns/10ps
`default_nettype none
// Operation
// RQ1: transactions run reset/presence, rom command, memory command, then data.
// RQ2: after presence one rom command of exactly eight bits follows.
// RQ3: command 33h sends family code, 48-bit serial, crc, lsb first.
// RQ4: command 55h compares 64 bits; mismatch stays silent until reset.
// RQ5: command CCh goes straight to memory command reception.
// RQ6: command F0h: send bit, send complement, receive chosen bit.
// RQ7: search bit mismatch drops the device out until reset.
// RQ8: command ECh searches only with unacknowledged interrupt, else silent.
// RQ9: master holds reset low at least 480 us, then releases.
// RQ10: after reset rise wait 15-60 us, then presence low 60-240 us.
// RQ11: master samples the bus 480 us after reset to see interrupts.
// RQ12: master keeps reset low plus release time under 960 us.
// RQ13: each slot starts at a falling edge that starts the sample delay.
// RQ14: read slot zero holds line low for the delay; one releases.
// RQ15: alarm sets its flag; enabled alarm pulls interrupt output low.
// RQ16: condition ends on status read or enable bit set to one.
// RQ17: reset arms spontaneous interrupt, any falling edge disarms it; the code disarms only on falls while drive is off.
// RQ18: armed spontaneous interrupt pulls bus low 960-3840 us, then presence.
// RQ19: alarm during presence postpones the pulse until presence ends.
// RQ20: unsent interrupt stretches the next reset to 960-3840 us low.
// RQ21: alarm during reset low asserts the pulse at once.
// RQ22: at power-on send presence, stretch next reset, send presence again; the code stretches the next reset only with an enabled flag set.
// RQ23: signal at every reset until acknowledged, delayed or after presence.
// RQ24: bus idles high; low beyond 120 us may reset devices.
module owsl_slave #(
	// arbitrary identity value, not tied to any product
	parameter logic [63:0] ROM_ID            = 64'hA5C3_0000_1234_5601,
	parameter int unsigned RESET_DETECT_CYC  = owsl_pkg::RESET_DETECT_CYC,
	parameter int unsigned PRESENCE_LOW_CYC  = owsl_pkg::PRESENCE_LOW_CYC,
	parameter int unsigned IRQ_PULSE_CYC     = owsl_pkg::IRQ_PULSE_CYC,
	parameter int unsigned SLOT_SAMPLE_CYC   = owsl_pkg::SLOT_SAMPLE_CYC,
	parameter int unsigned PRESENCE_WAIT_CYC = owsl_pkg::PRESENCE_WAIT_CYC
) (
	input  wire logic                  clk_i,
	input  wire logic                  arst_n_i,
	input  wire logic                  line_i,
	output logic                       line_o,
	output logic                       line_oe_o,
	output logic                       irq_o,
	output logic                       irq_oe_o,
	input  wire owsl_pkg::owsl_alarm_s alarm_i,
	input  wire owsl_pkg::owsl_alarm_s irq_en_n_i,
	input  wire logic                  status_rd_i,
	output logic [7:0]                 status_o,
	output logic                       mem_active_o,
	output logic                       mem_rx_bit_o,
	output logic                       mem_rx_valid_o,
	input  wire logic                  mem_tx_bit_i
);
	import owsl_pkg::*;

	localparam logic [TMR_W-1:0] T_SAMPLE = TMR_W'(SLOT_SAMPLE_CYC - 1);
	localparam logic [TMR_W-1:0] T_PWAIT  = TMR_W'(PRESENCE_WAIT_CYC - 1);
	localparam logic [TMR_W-1:0] T_PLOW   = TMR_W'(PRESENCE_LOW_CYC - 1);
	localparam logic [TMR_W-1:0] T_RDET   = TMR_W'(RESET_DETECT_CYC - 1);
	localparam logic [TMR_W-1:0] T_IRQ    = TMR_W'(IRQ_PULSE_CYC - 1);

	logic ln;
	logic fall;
	logic rise;

	owsl_line_sync u_sync (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.line_i   (line_i),
		.level_o  (ln),
		.fall_o   (fall),
		.rise_o   (rise)
	);

	// fsm and slot engine state
	owsl_state_e      state;
	owsl_state_e      next_state;
	logic [TMR_W-1:0] tmr;
	logic [TMR_W-1:0] next_tmr;
	logic [TMR_W-1:0] slot_tmr;
	logic [TMR_W-1:0] next_slot_tmr;
	logic             slot_busy;
	logic             next_slot_busy;
	logic             drive;
	logic             next_drive;
	logic [7:0]       cmd;
	logic [7:0]       next_cmd;
	logic [5:0]       bitn;
	logic [5:0]       next_bitn;
	logic [1:0]       phase;
	logic [1:0]       next_phase;
	logic             stretched;
	logic             next_stretched;
	logic             rx_bit;
	logic             next_rx_bit;
	logic             rx_valid;
	logic             next_rx_valid;

	// reset pulse detection
	logic [TMR_W-1:0] low_cnt;
	logic [TMR_W-1:0] next_low_cnt;
	logic             rst_seen;
	logic             next_rst_seen;
	logic             reset_evt;

	// interrupt state
	logic [2:0] flags;
	logic [2:0] next_flags;
	logic       cond_q;
	logic       next_cond_q;
	logic       armed;
	logic       next_armed;
	logic       spont_pend;
	logic       next_spont_pend;
	logic       self_comm;
	logic       next_self_comm;
	logic       irq_cond;
	logic       go_spont;
	logic       go_stretch;

	// slot decode helpers
	logic       tx_en;
	logic       tx_bit;
	logic       slot_done;
	logic       rom_bit;
	logic [7:0] cmd_full;

	assign irq_cond = |(flags & ~irq_en_n_i); // RQ15 RQ16
	assign reset_evt = rise & rst_seen;
	assign rom_bit = ROM_ID[bitn];
	assign slot_done = slot_busy && (slot_tmr == T_SAMPLE);
	assign cmd_full = {ln, cmd[7:1]};

	// spontaneous pulse only on a quiet, armed, high line
	assign go_spont = spont_pend && armed && irq_cond && ln && !drive
		&& !slot_busy && (state == S_ROM_CMD || state == S_SILENT); // RQ17 RQ19
	// reset seen low and no self communication: lengthen it
	assign go_stretch = rst_seen && !ln && irq_cond && !self_comm
		&& !stretched && (state != S_IRQ_PULSE); // RQ20 RQ21 RQ23

	always_comb begin
		tx_en  = 1'b0;
		tx_bit = 1'b1;
		case (state)
			S_READ_ROM: begin
				tx_en  = 1'b1;
				tx_bit = rom_bit; // RQ3
			end
			S_SEARCH: begin
				tx_en  = (phase != 2'd2);
				tx_bit = (phase == 2'd0) ? rom_bit : ~rom_bit; // RQ6
			end
			S_MEM: begin
				tx_en  = 1'b1;
				tx_bit = mem_tx_bit_i;
			end
			default: begin
				tx_en  = 1'b0;
				tx_bit = 1'b1;
			end
		endcase
	end

	// low time counter; a low counts as a reset when it reaches the detect count while drive is off
	always_comb begin
		next_low_cnt  = low_cnt;
		next_rst_seen = rst_seen;
		if (ln) begin
			next_low_cnt = '0;
		end else if (low_cnt != T_RDET) begin
			next_low_cnt = low_cnt + 1'b1;
		end
		if (!ln && !drive && low_cnt == T_RDET) begin
			next_rst_seen = 1'b1; // RQ24
		end else if (rise) begin
			next_rst_seen = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			low_cnt  <= '0;
			rst_seen <= 1'b0;
		end else begin
			low_cnt  <= next_low_cnt;
			rst_seen <= next_rst_seen;
		end
	end

	always_comb begin
		next_state     = state;
		next_tmr       = tmr;
		next_slot_tmr  = slot_tmr;
		next_slot_busy = slot_busy;
		next_drive     = drive;
		next_cmd       = cmd;
		next_bitn      = bitn;
		next_phase     = phase;
		next_stretched = stretched;
		next_rx_bit    = rx_bit;
		next_rx_valid  = 1'b0;
		// slot engine: fall starts the delay, expiry samples the line
		if (fall && !drive && state >= S_ROM_CMD && state <= S_MEM) begin
			next_slot_busy = 1'b1;
			next_slot_tmr  = '0;
			next_drive     = tx_en && !tx_bit; // RQ13 RQ14
		end else if (slot_busy) begin
			next_slot_tmr = slot_tmr + 1'b1;
			if (slot_done) begin
				next_slot_busy = 1'b0;
				next_drive     = 1'b0; // RQ14
			end
		end
		if (slot_done) begin
			case (state)
				S_ROM_CMD: begin
					next_cmd  = cmd_full; // RQ2
					next_bitn = bitn + 1'b1;
					if (bitn == 6'd7) begin
						next_bitn  = '0;
						next_phase = '0;
						if (cmd_full == CMD_READ_ROM) begin
							next_state = S_READ_ROM; // RQ3
						end else if (cmd_full == CMD_MATCH_ROM) begin
							next_state = S_MATCH; // RQ4
						end else if (cmd_full == CMD_SKIP_ROM) begin
							next_state = S_MEM; // RQ5
						end else if (cmd_full == CMD_SEARCH_ROM) begin
							next_state = S_SEARCH; // RQ6
						end else if (cmd_full == CMD_SEARCH_IRQ) begin
							next_state = irq_cond ? S_SEARCH : S_SILENT; // RQ8
						end else begin
							next_state = S_SILENT;
						end
					end
				end
				S_READ_ROM: begin
					next_bitn = bitn + 1'b1;
					if (bitn == 6'd63) begin
						next_state = S_MEM;
					end
				end
				S_MATCH: begin
					next_bitn = bitn + 1'b1;
					if (ln != rom_bit) begin
						next_state = S_SILENT; // RQ4
					end else if (bitn == 6'd63) begin
						next_state = S_MEM; // RQ4
					end
				end
				S_SEARCH: begin
					next_phase = phase + 1'b1;
					if (phase == 2'd2) begin
						next_phase = '0;
						next_bitn  = bitn + 1'b1;
						if (ln != rom_bit) begin
							next_state = S_SILENT; // RQ7
						end else if (bitn == 6'd63) begin
							next_state = S_MEM;
						end
					end
				end
				S_MEM: begin
					next_rx_bit   = ln; // RQ1
					next_rx_valid = 1'b1;
				end
				default: begin
					next_state = state;
				end
			endcase
		end
		case (state)
			S_PRES_WAIT: begin
				next_tmr = ln ? tmr + 1'b1 : '0;
				if (ln && tmr == T_PWAIT) begin
					next_state = S_PRES_LOW; // RQ10
					next_tmr   = '0;
					next_drive = 1'b1;
				end
			end
			S_PRES_LOW: begin
				next_tmr = tmr + 1'b1;
				if (tmr == T_PLOW) begin
					next_state = S_ROM_CMD; // RQ10 RQ1
					next_tmr   = '0;
					next_drive = 1'b0;
					next_bitn  = '0;
				end
			end
			S_IRQ_PULSE: begin
				next_tmr = tmr + 1'b1;
				if (tmr == T_IRQ) begin
					next_state = S_PRES_WAIT; // RQ18
					next_tmr   = '0;
					next_drive = 1'b0;
				end
			end
			default: begin
				next_tmr = tmr;
			end
		endcase
		// a detected reset aborts any transfer; selection lapses
		if (reset_evt && state != S_IRQ_PULSE) begin
			next_state     = S_PRES_WAIT; // RQ1 RQ4 RQ7
			next_tmr       = '0;
			next_slot_busy = 1'b0;
			next_drive     = 1'b0;
			next_bitn      = '0;
		end
		if (reset_evt) begin
			next_stretched = 1'b0;
		end
		if (go_stretch || go_spont) begin
			next_state     = S_IRQ_PULSE; // RQ18 RQ20 RQ21
			next_tmr       = '0;
			next_slot_busy = 1'b0;
			next_drive     = 1'b1;
			next_stretched = go_stretch;
		end
	end

	// power-on begins with a presence pulse
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state     <= S_PRES_WAIT; // RQ22
			tmr       <= '0;
			slot_tmr  <= '0;
			slot_busy <= 1'b0;
			drive     <= 1'b0;
			cmd       <= '0;
			bitn      <= '0;
			phase     <= '0;
			stretched <= 1'b0;
			rx_bit    <= 1'b0;
			rx_valid  <= 1'b0;
		end else begin
			state     <= next_state;
			tmr       <= next_tmr;
			slot_tmr  <= next_slot_tmr;
			slot_busy <= next_slot_busy;
			drive     <= next_drive;
			cmd       <= next_cmd;
			bitn      <= next_bitn;
			phase     <= next_phase;
			stretched <= next_stretched;
			rx_bit    <= next_rx_bit;
			rx_valid  <= next_rx_valid;
		end
	end

	always_comb begin
		// an alarm in the clearing cycle survives: set wins
		next_flags = (flags & ~{3{status_rd_i}}) | alarm_i; // RQ15 RQ16
		next_cond_q = irq_cond;
		next_armed = armed;
		if (fall && !drive) begin
			next_armed = 1'b0; // RQ17
		end else if (reset_evt) begin
			next_armed = 1'b1; // RQ17
		end
		// tells of the session a reset ends, so the reset clears it first
		next_self_comm = self_comm;
		if (reset_evt) begin
			next_self_comm = 1'b0;
		end else if (state == S_MEM) begin
			next_self_comm = 1'b1;
		end
		next_spont_pend = spont_pend;
		if (!irq_cond || go_spont || go_stretch) begin
			next_spont_pend = 1'b0;
		end else if (irq_cond && !cond_q) begin
			next_spont_pend = 1'b1; // RQ18 RQ19
		end else if (reset_evt && self_comm) begin
			next_spont_pend = 1'b1; // RQ23
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flags      <= ALARM_STATUS_RESET[2:0];
			cond_q     <= 1'b0;
			armed      <= 1'b0;
			spont_pend <= 1'b0;
			self_comm  <= 1'b0;
		end else begin
			flags      <= next_flags;
			cond_q     <= next_cond_q;
			armed      <= next_armed;
			spont_pend <= next_spont_pend;
			self_comm  <= next_self_comm;
		end
	end

	assign line_o         = 1'b0;
	assign line_oe_o      = drive;
	assign irq_o          = 1'b0;
	assign irq_oe_o       = cond_q; // RQ15
	assign status_o       = {5'h00, flags};
	assign mem_active_o   = (state == S_MEM);
	assign mem_rx_bit_o   = rx_bit;
	assign mem_rx_valid_o = rx_valid;
endmodule // owsl_slave
`default_nettype wire

// [owsl_slave_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module owsl_slave_sva
	import owsl_pkg::*;
#(
	parameter int unsigned RESET_DETECT_CYC = 24000,
	parameter int unsigned PRESENCE_LOW_CYC = 12000,
	parameter int unsigned IRQ_PULSE_CYC    = 192000,
	parameter int unsigned SLOT_SAMPLE_CYC  = 3000,
	parameter int unsigned PRESENCE_WAIT_CYC = 3000
) (
	input  wire logic                  clk_i,
	input  wire logic                  arst_n_i,
	input  wire logic                  line_i,
	input  wire logic                  line_o,
	input  wire logic                  line_oe_o,
	input  wire logic                  irq_o,
	input  wire logic                  irq_oe_o,
	input  wire owsl_pkg::owsl_alarm_s alarm_i,
	input  wire owsl_pkg::owsl_alarm_s irq_en_n_i,
	input  wire logic                  status_rd_i,
	input  wire logic [7:0]            status_o,
	input  wire logic                  mem_active_o,
	input  wire logic                  mem_rx_bit_o,
	input  wire logic                  mem_rx_valid_o,
	input  wire logic                  mem_tx_bit_i
);
	// windows from the line edge, sync latency included
	localparam int unsigned PW_MIN = PRESENCE_WAIT_CYC;
	localparam int unsigned PW_MAX = PRESENCE_WAIT_CYC + 10;
	localparam int unsigned WS_MIN = SLOT_SAMPLE_CYC;
	localparam int unsigned WS_MAX = SLOT_SAMPLE_CYC + 10;
	int unsigned oe_cnt;
	int unsigned lo_cnt;
	// waits for a delay range are counted here, then checked against both ends
	int unsigned pw_cnt;
	int unsigned ws_cnt;
	logic        line_q;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			oe_cnt <= 0;
			lo_cnt <= 0;
			pw_cnt <= 0;
			ws_cnt <= 0;
			line_q <= 1'b1;
		end else begin
			oe_cnt <= line_oe_o ? oe_cnt + 1 : 0;
			lo_cnt <= line_i ? 0 : lo_cnt + 1;
			line_q <= line_i;
			if (line_i && !line_q && lo_cnt > RESET_DETECT_CYC + 10)
				pw_cnt <= 1;
			else if (line_oe_o)
				pw_cnt <= 0;
			else if (pw_cnt != 0)
				pw_cnt <= pw_cnt + 1;
			if (!line_i && line_q && mem_active_o && !line_oe_o)
				ws_cnt <= 1;
			else if (mem_rx_valid_o)
				ws_cnt <= 0;
			else if (ws_cnt != 0)
				ws_cnt <= ws_cnt + 1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	property p_flag_set;
		alarm_i.cycle |=> status_o[CYCLE_FLAG_POS];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("cycle flag not set after alarm");
	property p_irq_on;
		alarm_i.cycle && !irq_en_n_i.cycle ##1 !irq_en_n_i.cycle |=> irq_oe_o;
	endproperty
	a_irq_on: assert property (p_irq_on)
		else $error("interrupt output not pulled after alarm");
	property p_irq_off;
		status_rd_i && alarm_i == 3'h0 |=> status_o[2:0] == 3'h0 ##1 !irq_oe_o;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("status read did not end the condition");
	property p_irq_cause;
		irq_oe_o |-> ($past(status_o[2:0] & ~irq_en_n_i) != 3'h0);
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt output without enabled flag");
	property p_drive_max;
		$fell(line_oe_o) |-> oe_cnt <= IRQ_PULSE_CYC + 4;
	endproperty
	a_drive_max: assert property (p_drive_max)
		else $error("bus held low too long by device");
	property p_presence;
		pw_cnt <= PW_MAX;
	endproperty
	a_presence: assert property (p_presence)
		else $error("no presence pulse after reset");
	property p_presence_min;
		pw_cnt != 0 && line_oe_o |-> pw_cnt >= PW_MIN;
	endproperty
	a_presence_min: assert property (p_presence_min)
		else $error("presence pulse came too early");
	property p_rx_valid;
		mem_rx_valid_o |-> mem_active_o ##1 !mem_rx_valid_o;
	endproperty
	a_rx_valid: assert property (p_rx_valid)
		else $error("received bit strobe malformed");
	property p_write_sample;
		ws_cnt <= WS_MAX;
	endproperty
	a_write_sample: assert property (p_write_sample)
		else $error("slot not sampled after its delay");
	property p_write_early;
		ws_cnt != 0 && mem_rx_valid_o |-> ws_cnt >= WS_MIN;
	endproperty
	a_write_early: assert property (p_write_early)
		else $error("slot sampled before its delay");
	c_mem_bit: cover property (mem_rx_valid_o);
	c_irq: cover property ($rose(irq_oe_o));
	c_long: cover property ($fell(line_oe_o) && oe_cnt > IRQ_PULSE_CYC - 10);
endmodule // owsl_slave_sva
bind owsl_slave owsl_slave_sva #(
	.RESET_DETECT_CYC(RESET_DETECT_CYC),
	.PRESENCE_LOW_CYC(PRESENCE_LOW_CYC),
	.IRQ_PULSE_CYC(IRQ_PULSE_CYC),
	.SLOT_SAMPLE_CYC(SLOT_SAMPLE_CYC),
	.PRESENCE_WAIT_CYC(PRESENCE_WAIT_CYC)
) u_sva (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .line_i(line_i), .line_o(line_o),
	.line_oe_o(line_oe_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o),
	.alarm_i(alarm_i), .irq_en_n_i(irq_en_n_i), .status_rd_i(status_rd_i),
	.status_o(status_o), .mem_active_o(mem_active_o),
	.mem_rx_bit_o(mem_rx_bit_o), .mem_rx_valid_o(mem_rx_valid_o),
	.mem_tx_bit_i(mem_tx_bit_i)
);
`default_nettype wire

// [owsl_master_model.sv]
`timescale 1ns/10ps
`default_nettype none
module owsl_master_model #(
	parameter int unsigned SAMPLE_CYC = owsl_pkg::SLOT_SAMPLE_CYC
) (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      master_low_o
);
	localparam int SLOT_LEN = int'(SAMPLE_CYC) + 150;
	localparam int ZERO_END = int'(SAMPLE_CYC) + 50;
	localparam int READ_AT  = int'(SAMPLE_CYC) / 2;
	initial master_low_o = 1'b0;
	// every slot opens with a fall and outlasts the sample delay
	task automatic slot(input logic b, output logic got);
		master_low_o <= 1'b1;
		for (int n = 0; n < SLOT_LEN; n++) begin
			@(posedge clk_i);
			if (n == (b ? 5 : ZERO_END))
				master_low_o <= 1'b0;
			if (n == READ_AT)
				got = line_i;
		end
	endtask
	task automatic send_byte(input logic [7:0] c);
		logic d;
		for (int i = 0; i < 8; i++)
			slot(c[i], d);
	endtask
	// st: low after release, hi: wait, lo: presence; lo is -1 on timeout
	task automatic watch(output int st, output int hi, output int lo);
		int ph;
		ph = 0;
		st = 0;
		hi = 0;
		lo = 0;
		for (int n = 0; n < 40000 && ph < 3; n++) begin
			@(posedge clk_i);
			if (ph == 0 && line_i) ph = 1;
			else if (ph == 0) st++;
			else if (ph == 1 && line_i) hi++;
			else if (ph == 1) ph = 2;
			else if (line_i) ph = 3;
			else lo++;
		end
		if (ph < 3)
			lo = -1;
	endtask
	// held past the shortened detect count, well under 960 us
	task automatic bus_reset(output int st, output int hi, output int lo);
		master_low_o <= 1'b1;
		repeat (4000) @(posedge clk_i);
		master_low_o <= 1'b0;
		watch(st, hi, lo);
	endtask
endmodule // owsl_master_model
`default_nettype wire

// [owsl_slave_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module owsl_slave_bench;
	import owsl_pkg::*;
	localparam int RDC = 3500;
	localparam int PLC = 1000;
	localparam int IPC = 2000;
	// short slot and wait keep the run small
	localparam int SSC = 400;
	localparam int PWC = 400;
	// arbitrary identity value
	localparam logic [63:0] ROM = 64'h3C5A_0000_00C8_1E14;
	logic        clk_i, arst_n_i, master_low, line, line_o, line_oe;
	logic        irq_o, irq_oe, status_rd, mem_active, mem_rx_bit;
	logic        mem_rx_valid, mem_tx_bit;
	logic [7:0]  status;
	owsl_alarm_s alarm, irq_en_n;
	int          num_errors = 0;
	int          samples_checked = 0;
	// pull-up wins unless someone pulls low
	assign line = ~master_low & ~(line_oe & ~line_o);
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	owsl_slave #(.ROM_ID(ROM), .RESET_DETECT_CYC(RDC),
		.PRESENCE_LOW_CYC(PLC), .IRQ_PULSE_CYC(IPC),
		.SLOT_SAMPLE_CYC(SSC), .PRESENCE_WAIT_CYC(PWC)) uut (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .line_i(line), .line_o(line_o),
		.line_oe_o(line_oe), .irq_o(irq_o), .irq_oe_o(irq_oe),
		.alarm_i(alarm), .irq_en_n_i(irq_en_n), .status_rd_i(status_rd),
		.status_o(status), .mem_active_o(mem_active),
		.mem_rx_bit_o(mem_rx_bit), .mem_rx_valid_o(mem_rx_valid),
		.mem_tx_bit_i(mem_tx_bit));
	owsl_master_model #(.SAMPLE_CYC(SSC)) mdl (.clk_i(clk_i), .line_i(line),
		.master_low_o(master_low));
	task automatic tally_and_finish;
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rng(input int v, input int lo, input int hi);
		samples_checked++;
		if (v < lo || v > hi) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
		end
	endtask
	task automatic pres(input logic drv, output int st);
		int hi, lo;
		if (drv)
			mdl.bus_reset(st, hi, lo);
		else
			mdl.watch(st, hi, lo);
		if (lo < 0) begin
			num_errors++;
			tally_and_finish();
		end else begin
			rng(hi, PWC - 5, PWC + 5);
			rng(lo, PLC - 5, PLC + 5);
		end
	endtask
	task automatic trip(input logic wr, output logic [1:0] r);
		logic g;
		mdl.slot(1'b1, r[1]);
		mdl.slot(1'b1, r[0]);
		mdl.slot(wr, g);
	endtask
	task automatic t_power;
		int st;
		chk(status, ALARM_STATUS_RESET);
		chk({irq_o, line_o}, 2'b00);
		pres(1'b0, st);
	endtask
	task automatic t_skip;
		int st;
		logic g;
		pres(1'b1, st);
		mdl.send_byte(CMD_SKIP_ROM);
		chk(mem_active, 1'b1);
		mdl.slot(1'b0, g);
		chk(mem_rx_bit, 1'b0);
		mdl.slot(1'b1, g);
		chk(mem_rx_bit, 1'b1);
		mem_tx_bit <= 1'b0;
		mdl.slot(1'b1, g);
		mem_tx_bit <= 1'b1;
		chk(g, 1'b0);
	endtask
	task automatic t_read;
		int st;
		logic [7:0] b;
		pres(1'b1, st);
		mdl.send_byte(CMD_READ_ROM);
		for (int i = 0; i < 8; i++)
			mdl.slot(1'b1, b[i]);
		chk(b, ROM[7:0]);
	endtask
	task automatic t_match;
		int st;
		logic g;
		pres(1'b1, st);
		mdl.send_byte(CMD_MATCH_ROM);
		mdl.slot(~ROM[0], g);
		mdl.slot(1'b1, g);
		chk({g, mem_active}, 2'b10);
	endtask
	task automatic t_search;
		int st;
		logic g;
		logic [1:0] r;
		pres(1'b1, st);
		mdl.send_byte(CMD_SEARCH_ROM);
		trip(ROM[0], r);
		mdl.slot(1'b1, g);
		chk({r, g}, {ROM[0], ~ROM[0], ROM[1]});
	endtask
	task automatic t_ech_off;
		int st;
		logic [1:0] r;
		pres(1'b1, st);
		mdl.send_byte(CMD_SEARCH_IRQ);
		trip(ROM[0], r);
		chk(r, 2'b11);
	endtask
	task automatic t_irq;
		int st, n, lo;
		logic g;
		logic [1:0] r;
		irq_en_n <= 3'h0;
		pres(1'b1, st);
		repeat (50) @(posedge clk_i);
		alarm.cycle <= 1'b1;
		@(posedge clk_i);
		alarm.cycle <= 1'b0;
		for (n = 0; n < 100 && line; n++) @(posedge clk_i);
		for (lo = 0; lo < 50000 && !line; lo++) @(posedge clk_i);
		rng(lo, IPC - 5, IPC + 5);
		chk({status, irq_oe}, 9'h003);
		pres(1'b0, st);
		pres(1'b1, st);
		rng(st, 1480, 1530);
		mdl.send_byte(CMD_SEARCH_IRQ);
		trip(~ROM[0], r);
		mdl.slot(1'b1, g);
		chk({r, g}, {ROM[0], ~ROM[0], 1'b1});
		irq_en_n <= 3'h7;
		repeat (3) @(posedge clk_i);
		chk(irq_oe, 1'b0);
		irq_en_n <= 3'h0;
		status_rd <= 1'b1;
		@(posedge clk_i);
		status_rd <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({status, irq_oe}, 9'h000);
	endtask
	initial begin
		arst_n_i = 1'b0;
		alarm = 3'h0;
		irq_en_n = 3'h7;
		status_rd = 1'b0;
		mem_tx_bit = 1'b1;
		repeat (3) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		t_power();
		t_skip();
		t_read();
		t_match();
		t_search();
		t_ech_off();
		t_irq();
		tally_and_finish();
	end
endmodule // owsl_slave_bench
`default_nettype wire
